// ==== include/ssr_pkg.sv ====
package ssr_pkg;
  // register offsets, shared by both access sources except the sequencer-only indirect slots
  localparam logic [7:0] SEQ_CTRL_OFF = 8'h00;
  localparam logic [7:0] XFER_CTRL0_OFF = 8'h01;
  localparam logic [7:0] XFER_CTRL1_OFF = 8'h02;
  localparam logic [7:0] BUS_SIG_OFF = 8'h03;
  localparam logic [7:0] RATE_OFF = 8'h04;
  localparam logic [7:0] BUS_ID_OFF = 8'h05;
  localparam logic [7:0] DATA_LO_OFF = 8'h06;
  localparam logic [7:0] DATA_HI_OFF = 8'h07;
  localparam logic [7:0] COUNT_B0_OFF = 8'h08;
  localparam logic [7:0] COUNT_B1_OFF = 8'h09;
  localparam logic [7:0] COUNT_B2_OFF = 8'h0a;
  localparam logic [7:0] STATUS0_OFF = 8'h0b;
  localparam logic [7:0] STATUS1_OFF = 8'h0c;
  localparam logic [7:0] STATUS2_OFF = 8'h0d;
  localparam logic [7:0] STATUS3_OFF = 8'h0e;
  localparam logic [7:0] TEST_CTRL_OFF = 8'h0f;
  localparam logic [7:0] IRQ_MASK0_OFF = 8'h10;
  localparam logic [7:0] IRQ_MASK1_OFF = 8'h11;
  localparam logic [7:0] LINES_LO_OFF = 8'h12;
  localparam logic [7:0] LINES_HI_OFF = 8'h13;
  localparam logic [7:0] SHADOW_B0_OFF = 8'h14;
  localparam logic [7:0] SHADOW_B1_OFF = 8'h15;
  localparam logic [7:0] SHADOW_B2_OFF = 8'h16;
  localparam logic [7:0] SHADOW_B3_OFF = 8'h17;
  localparam logic [7:0] SEL_TIMER_OFF = 8'h18;
  localparam logic [7:0] SEL_ID_OFF = 8'h19;
  localparam logic [7:0] BLOCK_CTRL_OFF = 8'h1f;
  localparam logic [7:0] SEQ_CTL_OFF = 8'h60;
  localparam logic [7:0] SEQ_RAM_OFF = 8'h61;
  localparam logic [7:0] SEQ_PC_LO_OFF = 8'h62;
  localparam logic [7:0] SEQ_PC_HI_OFF = 8'h63;
  localparam logic [7:0] ACC_OFF = 8'h64;
  localparam logic [7:0] SRC_INDEX_OFF = 8'h65;
  localparam logic [7:0] DST_INDEX_OFF = 8'h66;
  localparam logic [7:0] BRK_LO_OFF = 8'h67;
  localparam logic [7:0] BRK_HI_OFF = 8'h68;
  localparam logic [7:0] ONES_OFF = 8'h69;
  localparam logic [7:0] ZEROS_OFF = 8'h6a;
  localparam logic [7:0] FLAGS_OFF = 8'h6b;
  localparam logic [7:0] SRC_IND_OFF = 8'h6c;
  localparam logic [7:0] DST_IND_OFF = 8'h6d;
  localparam logic [7:0] DECODER_OFF = 8'h6e;
  localparam logic [7:0] STACK_OFF = 8'h6f;
  // address windows
  localparam logic [7:0] SCSI_TOP = 8'h1f;
  localparam logic [7:0] SEQ_BASE = 8'h60;
  localparam logic [7:0] SEQ_TOP = 8'h6f;
  localparam int STORE_DEPTH = 48;
  localparam logic [5:0] SEQ_STORE_BASE = 6'h20;
  // implemented-bit masks
  localparam logic [7:0] MASK_ALL = 8'hff;
  localparam logic [7:0] MASK_NONE = 8'h00;
  localparam logic [7:0] MASK_XFER_CTRL0 = 8'hde;
  localparam logic [7:0] MASK_CLEAR0 = 8'h7a;
  localparam logic [7:0] MASK_CLEAR1 = 8'hef;
  localparam logic [7:0] MASK_STATUS2 = 8'h9f;
  localparam logic [7:0] MASK_TEST_CTRL = 8'h17;
  localparam logic [7:0] MASK_IRQ_MASK0 = 8'h7f;
  localparam logic [7:0] MASK_SEL_TIMER = 8'hbf;
  localparam logic [7:0] MASK_SEL_ID = 8'hf8;
  localparam logic [7:0] MASK_BLOCK_CTRL = 8'he2;
  localparam logic [7:0] MASK_SEQ_PC_HI = 8'h01;
  localparam logic [7:0] MASK_BRK_HI = 8'h81;
  localparam logic [7:0] MASK_FLAGS = 8'h03;
  localparam logic [7:0] MASK_DECODER = 8'h70;
  localparam int DECODER_LSB = 4;
  localparam logic [7:0] DECODER_ONE = 8'h01;
  localparam logic [7:0] CONST_ONES = 8'hff;
  localparam logic [7:0] CONST_ZEROS = 8'h00;
  localparam logic [7:0] RESET_BYTE = 8'h00;
endpackage

// ==== verilog/ssr_reg_bank.sv ====
`timescale 1ns/100ps
module ssr_reg_bank (
  // clock and reset
  input wire logic clock,
  input wire logic clock_en,
  input wire logic rst_b,
  // host side access
  input wire logic [7:0] host_addr,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  output logic host_rvalid,
  // sequencer side access
  input wire logic [7:0] seq_addr,
  input wire logic seq_wr,
  input wire logic seq_rd,
  input wire logic [7:0] seq_wdata,
  output logic [7:0] seq_rdata,
  output logic seq_rvalid,
  // status from the scsi core
  input wire logic [7:0] bus_signal_in,
  input wire logic [7:0] bus_status_0,
  input wire logic [7:0] bus_status_1,
  input wire logic [7:0] bus_status_2,
  input wire logic [7:0] bus_status_3,
  input wire logic [15:0] bus_lines,
  input wire logic [31:0] host_addr_shadow,
  input wire logic [7:0] selection_timer_state,
  input wire logic [7:0] selecting_id,
  input wire logic [7:0] alu_flags,
  input wire logic [7:0] seq_stack_top,
  // control to the scsi core
  output logic [7:0] scsi_sequence_control,
  output logic [7:0] transfer_control_0,
  output logic [7:0] transfer_control_1,
  output logic [7:0] bus_signal_out,
  output logic [7:0] sync_rate_offset,
  output logic [7:0] bus_id_select,
  output logic [23:0] transfer_count,
  output logic [7:0] irq_mask_0,
  output logic [7:0] irq_mask_1,
  output logic [7:0] bus_test_control,
  output logic [7:0] block_control,
  output logic [7:0] clear_irq_status_0,
  output logic [7:0] clear_irq_status_1,
  // control to the sequencer
  output logic [7:0] seq_control,
  output logic [8:0] seq_program_counter,
  output logic [8:0] breakpoint_addr,
  output logic breakpoint_disable,
  output logic [7:0] seq_acc_register
);

  // stored bytes; scsi window at 0..31, sequencer window at 32..47
  logic [7:0] store_reg [ssr_pkg::STORE_DEPTH];
  logic [7:0] seq_eff_addr;
  logic seq_eff_wr;
  logic [7:0] host_rd_next;
  logic [7:0] seq_rd_next;

  // bits that a write keeps for each offset; zero where nothing is stored
  function automatic logic [7:0] write_mask(input logic [7:0] a);
    logic [7:0] m;
    m = ssr_pkg::MASK_NONE;
    case (a)
      ssr_pkg::SEQ_CTRL_OFF: m = ssr_pkg::MASK_ALL;
      ssr_pkg::XFER_CTRL0_OFF: m = ssr_pkg::MASK_XFER_CTRL0;
      ssr_pkg::XFER_CTRL1_OFF: m = ssr_pkg::MASK_ALL;
      ssr_pkg::BUS_SIG_OFF: m = ssr_pkg::MASK_ALL;
      ssr_pkg::RATE_OFF: m = ssr_pkg::MASK_ALL;
      ssr_pkg::BUS_ID_OFF: m = ssr_pkg::MASK_ALL;
      ssr_pkg::DATA_LO_OFF: m = ssr_pkg::MASK_ALL;
      ssr_pkg::DATA_HI_OFF: m = ssr_pkg::MASK_ALL;
      ssr_pkg::COUNT_B0_OFF: m = ssr_pkg::MASK_ALL;
      ssr_pkg::COUNT_B1_OFF: m = ssr_pkg::MASK_ALL;
      ssr_pkg::COUNT_B2_OFF: m = ssr_pkg::MASK_ALL;
      ssr_pkg::TEST_CTRL_OFF: m = ssr_pkg::MASK_TEST_CTRL;
      ssr_pkg::IRQ_MASK0_OFF: m = ssr_pkg::MASK_IRQ_MASK0;
      ssr_pkg::IRQ_MASK1_OFF: m = ssr_pkg::MASK_ALL;
      ssr_pkg::BLOCK_CTRL_OFF: m = ssr_pkg::MASK_BLOCK_CTRL;
      ssr_pkg::SEQ_CTL_OFF: m = ssr_pkg::MASK_ALL;
      ssr_pkg::SEQ_RAM_OFF: m = ssr_pkg::MASK_ALL;
      ssr_pkg::SEQ_PC_LO_OFF: m = ssr_pkg::MASK_ALL;
      ssr_pkg::SEQ_PC_HI_OFF: m = ssr_pkg::MASK_SEQ_PC_HI;
      ssr_pkg::ACC_OFF: m = ssr_pkg::MASK_ALL;
      ssr_pkg::SRC_INDEX_OFF: m = ssr_pkg::MASK_ALL;
      ssr_pkg::DST_INDEX_OFF: m = ssr_pkg::MASK_ALL;
      ssr_pkg::BRK_LO_OFF: m = ssr_pkg::MASK_ALL;
      ssr_pkg::BRK_HI_OFF: m = ssr_pkg::MASK_BRK_HI;
      ssr_pkg::DECODER_OFF: m = ssr_pkg::MASK_DECODER;
      default: m = ssr_pkg::MASK_NONE;
    endcase
    return m;
  endfunction

  // offset to storage slot; only meaningful where write_mask is non-zero
  function automatic logic [5:0] store_index(input logic [7:0] a);
    logic [5:0] idx;
    idx = {1'b0, a[4:0]};
    if (a >= ssr_pkg::SEQ_BASE)
    begin
      idx = ssr_pkg::SEQ_STORE_BASE | {2'b00, a[3:0]};
    end
    return idx;
  endfunction

  function automatic logic [7:0] stored(input logic [7:0] a);
    return store_reg[store_index(a)] & write_mask(a);
  endfunction

  // common read decode; indirect slots are not reachable here, which also
  // stops an index pointing at an indirect slot from recursing
  function automatic logic [7:0] read_byte(input logic [7:0] a);
    logic [7:0] d;
    d = ssr_pkg::CONST_ZEROS;
    case (a)
      ssr_pkg::BUS_SIG_OFF: d = bus_signal_in;
      ssr_pkg::STATUS0_OFF: d = bus_status_0;
      ssr_pkg::STATUS1_OFF: d = bus_status_1;
      ssr_pkg::STATUS2_OFF: d = bus_status_2 & ssr_pkg::MASK_STATUS2;
      ssr_pkg::STATUS3_OFF: d = bus_status_3;
      ssr_pkg::LINES_LO_OFF: d = bus_lines[7:0];
      ssr_pkg::LINES_HI_OFF: d = bus_lines[15:8];
      ssr_pkg::SHADOW_B0_OFF: d = host_addr_shadow[7:0];
      ssr_pkg::SHADOW_B1_OFF: d = host_addr_shadow[15:8];
      ssr_pkg::SHADOW_B2_OFF: d = host_addr_shadow[23:16];
      ssr_pkg::SHADOW_B3_OFF: d = host_addr_shadow[31:24];
      ssr_pkg::SEL_TIMER_OFF: d = selection_timer_state & ssr_pkg::MASK_SEL_TIMER;
      ssr_pkg::SEL_ID_OFF: d = selecting_id & ssr_pkg::MASK_SEL_ID;
      ssr_pkg::ONES_OFF: d = ssr_pkg::CONST_ONES;
      ssr_pkg::ZEROS_OFF: d = ssr_pkg::CONST_ZEROS;
      ssr_pkg::FLAGS_OFF: d = alu_flags & ssr_pkg::MASK_FLAGS;
      ssr_pkg::STACK_OFF: d = seq_stack_top;
      ssr_pkg::DECODER_OFF:
        d = ssr_pkg::DECODER_ONE << store_reg[store_index(a)][ssr_pkg::DECODER_LSB +: 3];
      ssr_pkg::SRC_IND_OFF: d = ssr_pkg::CONST_ZEROS;
      ssr_pkg::DST_IND_OFF: d = ssr_pkg::CONST_ZEROS;
      default: d = stored(a);
    endcase
    return d;
  endfunction

  // sequencer writes through dest-indirect land at the dest index
  always_comb
  begin
    seq_eff_addr = seq_addr;
    if (seq_addr == ssr_pkg::DST_IND_OFF)
    begin
      seq_eff_addr = store_reg[store_index(ssr_pkg::DST_INDEX_OFF)];
    end
    seq_eff_wr = seq_wr;
  end

  // read data; host side cannot see the sequencer-only indirect slots
  always_comb
  begin
    host_rd_next = read_byte(host_addr);
    seq_rd_next = read_byte(seq_addr);
    if (seq_addr == ssr_pkg::SRC_IND_OFF)
    begin
      seq_rd_next = read_byte(store_reg[store_index(ssr_pkg::SRC_INDEX_OFF)]);
    end
  end

  // shared storage; on a same-slot collision the sequencer write lands last
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < ssr_pkg::STORE_DEPTH; i++)
      begin
        store_reg[i] <= ssr_pkg::RESET_BYTE;
      end
    end
    else if (clock_en)
    begin
      if (host_wr && (write_mask(host_addr) != ssr_pkg::MASK_NONE))
      begin
        store_reg[store_index(host_addr)] <= host_wdata & write_mask(host_addr);
      end
      if (seq_eff_wr && (write_mask(seq_eff_addr) != ssr_pkg::MASK_NONE))
      begin
        store_reg[store_index(seq_eff_addr)] <= seq_wdata & write_mask(seq_eff_addr);
      end
    end
  end

  // clear strobes for the status bits, one cycle per write
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      clear_irq_status_0 <= ssr_pkg::RESET_BYTE;
      clear_irq_status_1 <= ssr_pkg::RESET_BYTE;
    end
    else if (clock_en)
    begin
      clear_irq_status_0 <= (((host_wr && host_addr == ssr_pkg::STATUS0_OFF) ? host_wdata : ssr_pkg::RESET_BYTE)
        | ((seq_eff_wr && seq_eff_addr == ssr_pkg::STATUS0_OFF) ? seq_wdata : ssr_pkg::RESET_BYTE))
        & ssr_pkg::MASK_CLEAR0;
      clear_irq_status_1 <= (((host_wr && host_addr == ssr_pkg::STATUS1_OFF) ? host_wdata : ssr_pkg::RESET_BYTE)
        | ((seq_eff_wr && seq_eff_addr == ssr_pkg::STATUS1_OFF) ? seq_wdata : ssr_pkg::RESET_BYTE))
        & ssr_pkg::MASK_CLEAR1;
    end
  end

  // registered read answers, one cycle after the strobe
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      host_rdata <= ssr_pkg::RESET_BYTE;
      host_rvalid <= 1'b0;
      seq_rdata <= ssr_pkg::RESET_BYTE;
      seq_rvalid <= 1'b0;
    end
    else if (clock_en)
    begin
      host_rvalid <= host_rd;
      seq_rvalid <= seq_rd;
      if (host_rd)
      begin
        host_rdata <= host_rd_next;
      end
      if (seq_rd)
      begin
        seq_rdata <= seq_rd_next;
      end
    end
  end

  // control copies from the stored bytes, registered so they leave from flops
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      scsi_sequence_control <= ssr_pkg::RESET_BYTE;
      transfer_control_0 <= ssr_pkg::RESET_BYTE;
      transfer_control_1 <= ssr_pkg::RESET_BYTE;
      bus_signal_out <= ssr_pkg::RESET_BYTE;
      sync_rate_offset <= ssr_pkg::RESET_BYTE;
      bus_id_select <= ssr_pkg::RESET_BYTE;
      transfer_count <= '0;
      irq_mask_0 <= ssr_pkg::RESET_BYTE;
      irq_mask_1 <= ssr_pkg::RESET_BYTE;
      bus_test_control <= ssr_pkg::RESET_BYTE;
      block_control <= ssr_pkg::RESET_BYTE;
      seq_control <= ssr_pkg::RESET_BYTE;
      seq_program_counter <= '0;
      breakpoint_addr <= '0;
      breakpoint_disable <= 1'b0;
      seq_acc_register <= ssr_pkg::RESET_BYTE;
    end
    else if (clock_en)
    begin
      // one cycle behind the store; a trade for flop-driven outputs
      scsi_sequence_control <= stored(ssr_pkg::SEQ_CTRL_OFF);
      transfer_control_0 <= stored(ssr_pkg::XFER_CTRL0_OFF);
      transfer_control_1 <= stored(ssr_pkg::XFER_CTRL1_OFF);
      bus_signal_out <= stored(ssr_pkg::BUS_SIG_OFF);
      sync_rate_offset <= stored(ssr_pkg::RATE_OFF);
      bus_id_select <= stored(ssr_pkg::BUS_ID_OFF);
      transfer_count <= {stored(ssr_pkg::COUNT_B2_OFF), stored(ssr_pkg::COUNT_B1_OFF),
        stored(ssr_pkg::COUNT_B0_OFF)};
      irq_mask_0 <= stored(ssr_pkg::IRQ_MASK0_OFF);
      irq_mask_1 <= stored(ssr_pkg::IRQ_MASK1_OFF);
      bus_test_control <= stored(ssr_pkg::TEST_CTRL_OFF);
      block_control <= stored(ssr_pkg::BLOCK_CTRL_OFF);
      seq_control <= stored(ssr_pkg::SEQ_CTL_OFF);
      // stored bytes are masked on write, so the raw slot bits are clean here
      seq_program_counter <= {store_reg[store_index(ssr_pkg::SEQ_PC_HI_OFF)][0], stored(ssr_pkg::SEQ_PC_LO_OFF)};
      breakpoint_addr <= {store_reg[store_index(ssr_pkg::BRK_HI_OFF)][0], stored(ssr_pkg::BRK_LO_OFF)};
      breakpoint_disable <= store_reg[store_index(ssr_pkg::BRK_HI_OFF)][7];
      seq_acc_register <= stored(ssr_pkg::ACC_OFF);
    end
  end

endmodule

// ==== verif/ssr_reg_bank_props.sv ====
`timescale 1ns/100ps
module ssr_reg_bank_props (
  // clock and reset
  input wire logic clock,
  input wire logic clock_en,
  input wire logic rst_b,
  // access ports
  input wire logic [7:0] host_addr,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [7:0] host_rdata,
  input wire logic host_rvalid,
  input wire logic [7:0] seq_addr,
  input wire logic seq_wr,
  input wire logic seq_rd,
  input wire logic [7:0] seq_wdata,
  input wire logic [7:0] seq_rdata,
  input wire logic seq_rvalid,
  // watched levels
  input wire logic [7:0] bus_status_2,
  input wire logic [7:0] seq_acc_register
);
  logic [2:0] dec_code;
  assign dec_code = seq_wdata[6:4];
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence dec_wr_s;
    clock_en && seq_wr && !host_wr && seq_addr == ssr_pkg::DECODER_OFF;
  endsequence
  sequence dec_rd_s;
    clock_en && seq_rd && !seq_wr && !host_wr && seq_addr == ssr_pkg::DECODER_OFF;
  endsequence
  // idle cycle after the write keeps the stored byte from moving under the check
  sequence acc_wr_s;
    clock_en && seq_wr && !host_wr && seq_addr == ssr_pkg::ACC_OFF ##1 clock_en && !seq_wr && !host_wr;
  endsequence
  host_answer_a: assert property (clock_en && host_rd |=> host_rvalid)
    else $error("host read not answered");
  seq_quiet_a: assert property (clock_en && !seq_rd |=> !seq_rvalid)
    else $error("sequencer answer without read");
  ones_read_a: assert property (clock_en && host_rd && host_addr == ssr_pkg::ONES_OFF |=> host_rdata == 8'hff)
    else $error("ones location wrong");
  zeros_read_a: assert property (clock_en && seq_rd && seq_addr == ssr_pkg::ZEROS_OFF
    |=> seq_rvalid && seq_rdata == 8'h00)
    else $error("zeros location wrong");
  unassigned_zero_a: assert property (clock_en && host_rd && (host_addr inside {[8'h1a:8'h1e], [8'h20:8'h5f],
    [8'h70:8'hff]}) |=> host_rdata == 8'h00)
    else $error("unassigned offset not zero");
  reserved_bits_a: assert property (clock_en && host_rd && host_addr == ssr_pkg::STATUS2_OFF
    |=> host_rdata == ($past(bus_status_2) & ssr_pkg::MASK_STATUS2))
    else $error("reserved status bits not zero");
  decoder_hot_a: assert property (dec_wr_s ##1 (!seq_wr && !host_wr) ##1 dec_rd_s
    |=> seq_rdata == (8'h01 << $past(dec_code, 3)))
    else $error("decoder not one-hot");
  acc_copy_a: assert property (acc_wr_s |=> seq_acc_register == $past(seq_wdata, 2))
    else $error("accumulator output lag wrong");
endmodule

// ==== verif/ssr_access_agent.sv ====
`timescale 1ns/100ps
module ssr_access_agent (
  // clock
  input wire logic clock,
  // host side
  output logic [7:0] host_addr,
  output logic host_wr,
  output logic host_rd,
  output logic [7:0] host_wdata,
  input wire logic [7:0] host_rdata,
  input wire logic host_rvalid,
  // sequencer side
  output logic [7:0] seq_addr,
  output logic seq_wr,
  output logic seq_rd,
  output logic [7:0] seq_wdata,
  input wire logic [7:0] seq_rdata,
  input wire logic seq_rvalid
);
  initial
  begin
    {host_wr, host_rd, seq_wr, seq_rd} = 4'h0;
    {host_addr, host_wdata, seq_addr, seq_wdata} = 32'h0;
  end
  // writers keep unused and reserved bits at zero
  function automatic logic [7:0] clean(input logic [7:0] a, input logic [7:0] d);
    case (a)
      8'h01: clean = d & 8'hde;
      8'h0b: clean = d & 8'h7a;
      8'h0c: clean = d & 8'hef;
      8'h0f: clean = d & 8'h17;
      8'h10: clean = d & 8'h7f;
      8'h1f: clean = d & 8'he2;
      8'h63: clean = d & 8'h01;
      8'h68: clean = d & 8'h81;
      8'h6e: clean = d & 8'h70;
      default: clean = d;
    endcase
  endfunction
  // one byte access, s picks the sequencer side; q is unknown unless answered
  task automatic xfer(input bit s, input bit w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge clock);
    if (s)
    begin
      seq_addr = a;
      seq_wdata = clean(a, d);
      seq_wr = w;
      seq_rd = !w;
    end
    else
    begin
      host_addr = a;
      host_wdata = clean(a, d);
      host_wr = w;
      host_rd = !w;
    end
    @(negedge clock);
    q = s ? (seq_rvalid ? seq_rdata : 8'hxx) : (host_rvalid ? host_rdata : 8'hxx);
    {host_wr, host_rd, seq_wr, seq_rd} = 4'h0;
    // released lines do not keep the last value
    {host_addr, host_wdata} = ~{host_addr, host_wdata};
    {seq_addr, seq_wdata} = ~{seq_addr, seq_wdata};
  endtask
endmodule

// ==== verif/testbench.sv ====
`timescale 1ns/100ps
module testbench;
  logic clock, clock_en, rst_b, host_wr, host_rd, seq_wr, seq_rd, host_rvalid, seq_rvalid;
  logic [7:0] host_addr, host_wdata, host_rdata, seq_addr, seq_wdata, seq_rdata, st, q;
  logic [7:0] bus_id_select, sync_rate_offset, seq_acc_register, clr0;
  int err_total = 0;
  int n_compared = 0;
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  ssr_access_agent agent_u (.clock, .host_addr, .host_wr, .host_rd, .host_wdata, .host_rdata, .host_rvalid,
    .seq_addr, .seq_wr, .seq_rd, .seq_wdata, .seq_rdata, .seq_rvalid);
  ssr_reg_bank dut_u (.clock, .clock_en, .rst_b, .host_addr, .host_wr, .host_rd, .host_wdata, .host_rdata,
    .host_rvalid, .seq_addr, .seq_wr, .seq_rd, .seq_wdata, .seq_rdata, .seq_rvalid,
    .bus_signal_in(st), .bus_status_0(st), .bus_status_1(st), .bus_status_2(st), .bus_status_3(st),
    .bus_lines({st, st}), .host_addr_shadow({4{st}}), .selection_timer_state(st), .selecting_id(st),
    .alu_flags(st), .seq_stack_top(st), .scsi_sequence_control(), .transfer_control_0(), .transfer_control_1(),
    .bus_signal_out(), .sync_rate_offset, .bus_id_select, .transfer_count(), .irq_mask_0(), .irq_mask_1(),
    .bus_test_control(), .block_control(), .clear_irq_status_0(clr0), .clear_irq_status_1(), .seq_control(),
    .seq_program_counter(), .breakpoint_addr(), .breakpoint_disable(), .seq_acc_register);
  task automatic finish_test();
    if (err_total == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input bit s, input logic [7:0] a, input logic [7:0] d);
    agent_u.xfer(s, 1'b1, a, d, q);
  endtask
  task automatic rd(input bit s, input logic [7:0] a, input logic [7:0] exp);
    agent_u.xfer(s, 1'b0, a, 8'h00, q);
    chk8(q, exp);
  endtask
  task automatic t_const();
    rd(1'b0, 8'h69, 8'hff);
    wr(1'b1, 8'h6a, 8'h55);
    rd(1'b1, 8'h6a, 8'h00);
    rd(1'b0, 8'h6a, 8'h00);
  endtask
  task automatic t_unassigned();
    logic [7:0] list [6] = '{8'h1a, 8'h1e, 8'h20, 8'h5f, 8'h70, 8'hff};
    foreach (list[i])
    begin
      rd(1'b0, list[i], 8'h00);
      rd(1'b1, list[i], 8'h00);
    end
    rd(1'b0, 8'h6c, 8'h00);
  endtask
  task automatic t_reserved();
    st = 8'hff;
    rd(1'b0, 8'h0d, 8'h9f);
    rd(1'b1, 8'h18, 8'hbf);
    rd(1'b0, 8'h19, 8'hf8);
    rd(1'b1, 8'h6b, 8'h03);
    wr(1'b0, 8'h0f, 8'hff);
    rd(1'b1, 8'h0f, 8'h17);
    st = 8'h00;
  endtask
  task automatic t_sides();
    wr(1'b1, 8'h64, 8'ha5);
    rd(1'b0, 8'h64, 8'ha5);
    chk8(seq_acc_register, 8'ha5);
    wr(1'b1, 8'h05, 8'h3c);
    rd(1'b0, 8'h05, 8'h3c);
    chk8(bus_id_select, 8'h3c);
    wr(1'b0, 8'h0b, 8'h7a);
    chk8(clr0, 8'h7a);
    @(negedge clock);
    chk8(clr0, 8'h00);
  endtask
  task automatic t_decoder();
    for (int c = 0; c < 8; c++)
    begin
      wr(1'b1, 8'h6e, 8'(c << 4));
      rd(c[0], 8'h6e, 8'h01 << c);
    end
  endtask
  task automatic t_indirect();
    wr(1'b1, 8'h66, 8'h04);
    wr(1'b1, 8'h6d, 8'haa);
    rd(1'b0, 8'h04, 8'haa);
    chk8(sync_rate_offset, 8'haa);
    wr(1'b1, 8'h65, 8'h07);
    wr(1'b0, 8'h07, 8'h5b);
    rd(1'b1, 8'h6c, 8'h5b);
  endtask
  initial
  begin
    rst_b = 1'b0;
    clock_en = 1'b1;
    st = 8'h00;
    repeat (8) @(negedge clock);
    rst_b = 1'b1;
    t_const();
    t_unassigned();
    t_reserved();
    t_sides();
    t_decoder();
    t_indirect();
    finish_test();
  end
  // about 100 cycles of traffic; cut a hang well after that
  initial
  begin
    repeat (2000) @(posedge clock);
    err_total++;
    finish_test();
  end
endmodule
bind ssr_reg_bank ssr_reg_bank_props props_u (.clock, .clock_en, .rst_b, .host_addr, .host_wr, .host_rd,
  .host_rdata, .host_rvalid, .seq_addr, .seq_wr, .seq_rd, .seq_wdata, .seq_rdata, .seq_rvalid, .bus_status_2,
  .seq_acc_register);
